// >>> fpe_cfg.svh
/*
 flash program/erase command block: offsets, codes, limits, timing counts.
 assumes inclusion by bare name from the design file.
*/
`ifndef FPE_CFG_SVH
`define FPE_CFG_SVH
// register word byte offsets (R0..R4 shadows, control, status, stack, md regs)
`define FPE_OFF_R0        8'h00
`define FPE_OFF_R1        8'h04
`define FPE_OFF_R2        8'h08
`define FPE_OFF_R3        8'h0C
`define FPE_OFF_R4        8'h10
`define FPE_OFF_CTRL      8'h14
`define FPE_OFF_STAT      8'h18
`define FPE_OFF_STACK     8'h1C
`define FPE_OFF_MDH       8'h20
`define FPE_OFF_MDL       8'h24
`define FPE_OFF_MDC       8'h28
`define FPE_OFF_TRIG      8'h2C
// ctrl bit positions
`define FPE_CTRL_MAP_BIT  0
`define FPE_CTRL_PROT_BIT 1
// opcodes
`define FPE_OP_SINGLE     12'h55A
`define FPE_OP_DOUBLE     12'hDD4
`define FPE_OP_BLOCK      12'hAA5
`define FPE_CMD_ERASE     16'hEEEE
`define FPE_CMD_PROT      16'hCCCC
`define FPE_CMD_STATUS    16'h7777
`define FPE_KEY_5555      16'h5555
`define FPE_KEY_3333      16'h3333
`define FPE_KEY_AAAA      16'hAAAA
// result codes
`define FPE_RC_OK         8'h00
`define FPE_RC_PROT       8'h01
`define FPE_RC_VPP        8'h02
`define FPE_RC_PROG_FAIL  8'h03
`define FPE_RC_ADDR       8'h04
`define FPE_RC_PERIOD     8'h05
`define FPE_RC_STACK      8'h06
`define FPE_RC_BANK       8'h07
`define FPE_RC_ERASE_FAIL 8'h08
`define FPE_RC_SRC        8'h09
`define FPE_RC_COUNT      8'h0A
`define FPE_RC_BAD        8'hFF
// limits
`define FPE_STACK_MIN     16'd50
`define FPE_SPAN_LIMIT    16'd16384
`define FPE_PERIOD_MIN    16'd30
`define FPE_PERIOD_MAX    16'd500
`define FPE_NUM_BANKS     4
`define FPE_RETRY_MAX     4'd4
// one cell operation step time in ns and the derived cycle count at 5 ns
`define FPE_STEP_NS       40
`define FPE_CLK_NS        5
`define FPE_STEP_CYC      ((`FPE_STEP_NS + `FPE_CLK_NS - 1) / `FPE_CLK_NS)
`endif

// >>> fpe_pkg.sv
/*
 types of the flash program/erase command block.
 assumes fpe_cfg.svh is on the include path.
*/
package fpe_pkg;
    typedef enum logic [2:0] {FPE_K_NONE, FPE_K_SINGLE, FPE_K_DOUBLE, FPE_K_BLOCK,
                              FPE_K_ERASE, FPE_K_PROT, FPE_K_STATUS} fpe_kind_t;
    typedef struct packed {
        logic        req;
        logic        wr;
        logic [7:0]  addr;
        logic [31:0] wdata;
    } fpe_bus_req_t;
    typedef struct packed {
        logic        req;
        logic        wr;
        logic [23:0] addr;
        logic [31:0] wdata;
    } fpe_cell_req_t;
endpackage

// >>> fpe_flash_cmd.sv
/*
 flash program/erase command sequencer with Avalon-MM register slave.
 assumes a flash cell port that answers with cell_ack_i/cell_ok_i, and software
 doing load R0..R4, unlock, read R0.
*/
// Our own choices: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/10ps
`include "fpe_cfg.svh"
// Behaviour
// RULE1: four banks, each 32 bits wide; code programs 16-bit words at 2-byte address steps
// RULE2: banks 16K/48K/96K/96K, erased individually
// RULE3: protection blocks non-flash fetch reads
// RULE4: bank0 plus 16K maps segment 0 or 1
// RULE5: bank1 ranges depend on segment mapping
// RULE6: software loads, unlocks, then reads R0
// RULE7: unlock is direct then indirect write
// RULE8: unlock data equals even target address; code checks only for an even flash address
// RULE9: result code placed in R0
// RULE10: need 50 free stack words
// RULE11: multiply registers may be overwritten
// RULE12: validate, execute, verify with retries
// RULE13: opcode upper twelve bits, segment low nibble
// RULE14: R1 offset, R2 low, R3 high
// RULE15: erase keys, bank copies must match
// RULE16: protection set needs four key values
// RULE17: R4 carries cpu period in ns
// RULE18: block span zero to below 16384
// RULE19: source paged, span bound, page limits
// RULE20: flash source pages depend on mapping
// RULE21: 00h ok, FFh bad command
// RULE22: only back-to-back same even address unlock
module fpe_flash_cmd
    import fpe_pkg::*;
#(
    parameter int ADDR_W = 24
)(
    input  wire logic              core_clk_i,
    input  wire logic              rstn_i,
    input  wire logic [7:0]        avs_address_i,
    input  wire logic              avs_read_i,
    input  wire logic              avs_write_i,
    input  wire logic [31:0]       avs_writedata_i,
    output logic [31:0]            avs_readdata_o,
    output logic                   avs_waitrequest_o,
    input  wire logic              vpp_present_i,
    input  wire logic [ADDR_W-1:0] fetch_addr_i,
    input  wire logic              fetch_from_flash_i,
    output logic                   fetch_allow_o,
    output fpe_cell_req_t          cell_req_o,
    input  wire logic              cell_ack_i,
    input  wire logic              cell_ok_i,
    output logic                   busy_o
);
    typedef enum {S_IDLE, S_CHECK, S_RUN, S_WAIT, S_DONE} fpe_state_t;

    function automatic logic [1:0] bank_of(input logic [ADDR_W-1:0] a, input logic map1); // [RULE2] [RULE5]
        logic [1:0] b;
        b = 2'd3;
        if (a < 24'h020000)
        begin
            if (map1)
                b = (a < 24'h014000) ? 2'd0 : 2'd1;
            else
                b = (a < 24'h004000) ? 2'd0 : 2'd1;
        end
        else if (a < 24'h038000)
            b = 2'd2;
        return b;
    endfunction

    function automatic logic in_flash(input logic [ADDR_W-1:0] a, input logic map1); // [RULE4] [RULE5]
        logic r;
        r = 1'b0;
        if (map1)
            r = (a >= 24'h010000) && (a < 24'h050000);
        else
            r = (a < 24'h008000) || ((a >= 24'h018000) && (a < 24'h050000));
        return r;
    endfunction

    // base address of a bank, used as the cell address of whole-bank operations
    function automatic logic [23:0] bank_base(input logic [1:0] bk, input logic map1); // [RULE2] [RULE4]
        logic [23:0] r;
        r = 24'h038000;
        case (bk)
            2'd0:    r = map1 ? 24'h010000 : 24'h000000;
            2'd1:    r = map1 ? 24'h014000 : 24'h004000;
            2'd2:    r = 24'h020000;
            default: r = 24'h038000;
        endcase
        return r;
    endfunction

    logic [15:0] r0_q, r1_q, r2_q, r3_q, r4_q;
    logic [15:0] mdh_q, mdl_q, mdc_q;
    logic [15:0] stack_free_q;
    logic        map1_q, prot_q;
    logic        arm_q;
    logic [23:0] arm_addr_q;
    fpe_state_t  st_q;
    fpe_kind_t   kind_q;
    logic [7:0]  rc_q;
    logic [23:0] dst_q, dst_end_q;
    logic [15:0] src_q;
    logic [15:0] data_q;
    logic        hi_q;
    logic [3:0]  retry_q;
    logic [15:0] step_q;
    fpe_cell_req_t cell_q;
    logic [31:0] rdata_q;
    logic        rvalid_q;
    logic [2:0]  vpp_sync_q;
    logic        vpp_ok_q;

    wire         acc_rd = avs_read_i && !rvalid_q;
    wire         wr_go  = avs_write_i;
    wire         sw_cfg = wr_go && (st_q == S_IDLE);
    wire  [11:0] opc    = r0_q[15:4];
    wire  [23:0] tgt    = {4'h0, r0_q[3:0], r1_q};
    wire  [15:0] span   = r2_q - r1_q;
    wire  [15:0] trig_w = avs_writedata_i[15:0];
    wire  [5:0]  src_pg = 6'(r3_q[15:14]);
    wire         src_ok = map1_q ? !(src_pg < 6'd2) : 1'b1; // [RULE19] [RULE20]
    wire         trig   = sw_cfg && (avs_address_i == `FPE_OFF_TRIG) && !trig_w[0]
                          && (in_flash({8'h00, trig_w}, map1_q) || in_flash({8'h01, trig_w}, map1_q)); // [RULE7]
    // erase and protect address a bank base, never the key values in r1
    wire  [23:0] cell_addr = (kind_q == FPE_K_ERASE) ? bank_base(r2_q[1:0], map1_q)
                           : (kind_q == FPE_K_PROT) ? bank_base(2'd0, map1_q) : dst_q;

    assign avs_waitrequest_o = avs_read_i && !rvalid_q;
    assign avs_readdata_o    = rdata_q;
    assign busy_o            = (st_q != S_IDLE);
    assign cell_req_o        = cell_q;
    assign fetch_allow_o     = !prot_q || fetch_from_flash_i || !in_flash(fetch_addr_i, map1_q); // [RULE3]

    always_ff @(posedge core_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            rdata_q  <= 32'h0;
            rvalid_q <= 1'b0;
        end
        else
        begin
            rvalid_q <= acc_rd;
            case (avs_address_i)
                `FPE_OFF_R0:    rdata_q <= {16'h0, r0_q};
                `FPE_OFF_R1:    rdata_q <= {16'h0, r1_q};
                `FPE_OFF_R2:    rdata_q <= {16'h0, r2_q};
                `FPE_OFF_R3:    rdata_q <= {16'h0, r3_q};
                `FPE_OFF_R4:    rdata_q <= {16'h0, r4_q};
                `FPE_OFF_CTRL:  rdata_q <= {30'h0, prot_q, map1_q};
                `FPE_OFF_STAT:  rdata_q <= {23'h0, busy_o, rc_q};
                `FPE_OFF_STACK: rdata_q <= {16'h0, stack_free_q};
                `FPE_OFF_MDH:   rdata_q <= {16'h0, mdh_q};
                `FPE_OFF_MDL:   rdata_q <= {16'h0, mdl_q};
                `FPE_OFF_MDC:   rdata_q <= {16'h0, mdc_q};
                default:        rdata_q <= 32'h0;
            endcase
        end
    end

    // vpp detect pin: three stages, level taken once the last two agree
    always_ff @(posedge core_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            vpp_sync_q <= 3'h0;
            vpp_ok_q   <= 1'b0;
        end
        else
        begin
            vpp_sync_q <= {vpp_sync_q[1:0], vpp_present_i};
            if (vpp_sync_q[1] == vpp_sync_q[2])
                vpp_ok_q <= vpp_sync_q[1];
        end
    end

    // unlock pairing: first write arms, second must be next bus write, same address
    always_ff @(posedge core_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            arm_q      <= 1'b0;
            arm_addr_q <= 24'h0;
        end
        else if (wr_go)
        begin
            arm_q      <= trig && !arm_q; // [RULE7] [RULE22]
            arm_addr_q <= {8'h00, trig_w};
        end
    end

    wire fire = trig && arm_q && (arm_addr_q == {8'h00, trig_w}); // [RULE8] [RULE22]

    always_ff @(posedge core_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            r0_q <= 16'h0; r1_q <= 16'h0; r2_q <= 16'h0; r3_q <= 16'h0; r4_q <= 16'h0;
            mdh_q <= 16'h0; mdl_q <= 16'h0; mdc_q <= 16'h0;
            stack_free_q <= 16'h0;
            map1_q <= 1'b0; prot_q <= 1'b0;
            st_q <= S_IDLE; kind_q <= FPE_K_NONE; rc_q <= `FPE_RC_OK;
            dst_q <= 24'h0; dst_end_q <= 24'h0; src_q <= 16'h0; data_q <= 16'h0;
            hi_q <= 1'b0; retry_q <= 4'h0; step_q <= 16'h0;
            cell_q <= '0;
        end
        else
        begin
            if (sw_cfg && !fire) // [RULE6] [RULE17]
            begin
                case (avs_address_i)
                    `FPE_OFF_R0:    r0_q <= avs_writedata_i[15:0];
                    `FPE_OFF_R1:    r1_q <= avs_writedata_i[15:0];
                    `FPE_OFF_R2:    r2_q <= avs_writedata_i[15:0];
                    `FPE_OFF_R3:    r3_q <= avs_writedata_i[15:0];
                    `FPE_OFF_R4:    r4_q <= avs_writedata_i[15:0];
                    `FPE_OFF_CTRL:  map1_q <= avs_writedata_i[`FPE_CTRL_MAP_BIT];
                    `FPE_OFF_STACK: stack_free_q <= avs_writedata_i[15:0];
                    `FPE_OFF_MDH:   mdh_q <= avs_writedata_i[15:0];
                    `FPE_OFF_MDL:   mdl_q <= avs_writedata_i[15:0];
                    `FPE_OFF_MDC:   mdc_q <= avs_writedata_i[15:0];
                    default:        ;
                endcase
            end
            case (st_q)
                S_IDLE:
                    if (fire)
                        st_q <= S_CHECK;
                S_CHECK:
                begin // [RULE12] [RULE13] [RULE14] [RULE15] [RULE16]
                    st_q   <= S_DONE;
                    rc_q   <= `FPE_RC_OK;
                    dst_q  <= tgt;
                    data_q <= r2_q;
                    hi_q   <= 1'b0;
                    retry_q <= 4'h0;
                    src_q  <= r3_q;
                    kind_q <= FPE_K_NONE;
                    if (r0_q == `FPE_CMD_STATUS)
                        kind_q <= FPE_K_STATUS;
                    else if (r0_q == `FPE_CMD_ERASE && r1_q == `FPE_KEY_5555)
                        kind_q <= FPE_K_ERASE;
                    else if (r0_q == `FPE_CMD_PROT && r1_q == `FPE_KEY_5555 && r2_q == `FPE_KEY_3333
                             && r3_q == `FPE_KEY_AAAA)
                        kind_q <= FPE_K_PROT;
                    else if (opc == `FPE_OP_SINGLE)
                        kind_q <= FPE_K_SINGLE;
                    else if (opc == `FPE_OP_DOUBLE)
                        kind_q <= FPE_K_DOUBLE;
                    else if (opc == `FPE_OP_BLOCK)
                        kind_q <= FPE_K_BLOCK;
                    if (r0_q != `FPE_CMD_STATUS && !(r0_q == `FPE_CMD_ERASE && r1_q == `FPE_KEY_5555)
                        && !(r0_q == `FPE_CMD_PROT && r1_q == `FPE_KEY_5555 && r2_q == `FPE_KEY_3333
                             && r3_q == `FPE_KEY_AAAA)
                        && opc != `FPE_OP_SINGLE && opc != `FPE_OP_DOUBLE && opc != `FPE_OP_BLOCK)
                        rc_q <= `FPE_RC_BAD; // [RULE21]
                    else if (r4_q < `FPE_PERIOD_MIN || r4_q > `FPE_PERIOD_MAX)
                        rc_q <= `FPE_RC_PERIOD;
                    else if (r0_q == `FPE_CMD_STATUS)
                        rc_q <= `FPE_RC_OK;
                    else if (stack_free_q < `FPE_STACK_MIN)
                        rc_q <= `FPE_RC_STACK; // [RULE10]
                    else if (!vpp_ok_q)
                        rc_q <= `FPE_RC_VPP;
                    else if (prot_q && r0_q != `FPE_CMD_PROT)
                        rc_q <= `FPE_RC_PROT;
                    else if (r0_q == `FPE_CMD_ERASE)
                    begin
                        if (r2_q != r3_q || r2_q >= 16'(`FPE_NUM_BANKS))
                            rc_q <= `FPE_RC_BANK;
                        else
                            st_q <= S_RUN;
                    end
                    else if (r0_q == `FPE_CMD_PROT)
                        st_q <= S_RUN;
                    else if (r1_q[0] || !in_flash(tgt, map1_q))
                        rc_q <= `FPE_RC_ADDR;
                    else if (opc == `FPE_OP_BLOCK && (r2_q[0] || r2_q < r1_q || span >= `FPE_SPAN_LIMIT))
                        rc_q <= `FPE_RC_COUNT; // [RULE18]
                    else if (opc == `FPE_OP_BLOCK && (!src_ok || 17'(r3_q) + 17'(span) >= 17'(`FPE_SPAN_LIMIT)))
                        rc_q <= `FPE_RC_SRC; // [RULE19]
                    else
                    begin
                        st_q <= S_RUN;
                        dst_end_q <= (opc == `FPE_OP_BLOCK) ? {4'h0, r0_q[3:0], r2_q} : tgt;
                    end
                end
                S_RUN:
                begin // [RULE1] [RULE11]
                    mdh_q <= 16'h0;
                    mdl_q <= 16'h0;
                    mdc_q <= 16'h0;
                    cell_q.req   <= 1'b1;
                    cell_q.wr    <= (kind_q != FPE_K_ERASE);
                    cell_q.addr  <= cell_addr;
                    cell_q.wdata <= (kind_q == FPE_K_BLOCK) ? {8'h00, 4'h0, r0_q[3:0], src_q}
                                                             : {16'h0, (hi_q ? r3_q : data_q)};
                    step_q <= 16'(`FPE_STEP_CYC);
                    st_q   <= S_WAIT;
                end
                S_WAIT:
                begin
                    if (step_q != 16'h0)
                        step_q <= step_q - 16'h1;
                    if (cell_ack_i && step_q == 16'h0)
                    begin
                        cell_q.req <= 1'b0;
                        if (!cell_ok_i)
                        begin
                            retry_q <= retry_q + 4'h1; // [RULE12]
                            st_q    <= (retry_q == `FPE_RETRY_MAX) ? S_DONE : S_RUN;
                            if (retry_q == `FPE_RETRY_MAX)
                                rc_q <= (kind_q == FPE_K_ERASE) ? `FPE_RC_ERASE_FAIL : `FPE_RC_PROG_FAIL;
                        end
                        else if (kind_q == FPE_K_PROT)
                        begin
                            prot_q <= 1'b1;
                            st_q   <= S_DONE;
                        end
                        else if (kind_q == FPE_K_DOUBLE && !hi_q)
                        begin
                            hi_q <= 1'b1;
                            dst_q <= dst_q + 24'h2;
                            retry_q <= 4'h0;
                            st_q <= S_RUN;
                        end
                        else if (kind_q == FPE_K_BLOCK && dst_q != dst_end_q)
                        begin
                            dst_q <= dst_q + 24'h2;
                            src_q <= src_q + 16'h2;
                            retry_q <= 4'h0;
                            st_q <= S_RUN;
                        end
                        else
                            st_q <= S_DONE;
                    end
                end
                S_DONE:
                begin
                    r0_q <= {8'h00, rc_q}; // [RULE9] [RULE21]
                    if (kind_q == FPE_K_BLOCK)
                        r1_q <= dst_q[15:0];
                    st_q <= S_IDLE;
                end
                default:
                    st_q <= S_IDLE;
            endcase
        end
    end

endmodule // fpe_flash_cmd

// >>> fpe_flash_cmd_sva.sv
/*
 assertion checker for the flash program/erase command block.
 assumes binding to fpe_flash_cmd: one clock, asynchronous active-low reset.
*/
`timescale 1ns/10ps
module fpe_flash_cmd_chk
    import fpe_pkg::*;
#(
    parameter int ADDR_W = 24
)(
    input wire logic              core_clk_i,
    input wire logic              rstn_i,
    input wire logic [7:0]        avs_address_i,
    input wire logic              avs_read_i,
    input wire logic              avs_write_i,
    input wire logic [31:0]       avs_writedata_i,
    input wire logic [31:0]       avs_readdata_o,
    input wire logic              avs_waitrequest_o,
    input wire logic              vpp_present_i,
    input wire logic [ADDR_W-1:0] fetch_addr_i,
    input wire logic              fetch_from_flash_i,
    input wire logic              fetch_allow_o,
    input wire fpe_cell_req_t     cell_req_o,
    input wire logic              cell_ack_i,
    input wire logic              cell_ok_i,
    input wire logic              busy_o
);
    wire trig_wr = avs_write_i && (avs_address_i == 8'h2C);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rstn_i);
    a_fetch_flash_ok: assert property (fetch_from_flash_i |-> fetch_allow_o) else $error("flash fetch blocked");
    a_fetch_outside_ok: assert property (fetch_addr_i >= 24'h050000 |-> fetch_allow_o) else $error("outside blocked");
    a_write_no_wait: assert property (avs_write_i |-> !avs_waitrequest_o) else $error("write stalled");
    a_read_first_wait: assert property ($rose(avs_read_i) |-> avs_waitrequest_o) else $error("read no wait");
    a_read_one_wait: assert property (avs_read_i && avs_waitrequest_o |=> !avs_waitrequest_o) else $error("read wait long");
    a_cell_addr_even: assert property (cell_req_o.req |-> !cell_req_o.addr[0]) else $error("odd cell address");
    a_cell_in_flash: assert property (cell_req_o.req |-> cell_req_o.addr < 24'h050000) else $error("cell outside");
    a_cell_idle_quiet: assert property (!busy_o |-> !cell_req_o.req) else $error("cell request while idle");
    a_cell_req_hold: assert property (cell_req_o.req && !cell_ack_i |=> cell_req_o.req && $stable(cell_req_o.addr))
        else $error("cell request dropped");
    a_trig_start: assert property ($rose(busy_o) |-> $past(trig_wr) || $past(trig_wr, 2))
        else $error("start without unlock");
    c_done: cover property ($fell(busy_o));
    c_fetch_block: cover property (!fetch_allow_o);
    c_cell_fail: cover property (cell_ack_i && !cell_ok_i && cell_req_o.req);
endmodule // fpe_flash_cmd_chk

bind fpe_flash_cmd fpe_flash_cmd_chk #(.ADDR_W(ADDR_W)) fpe_flash_cmd_chk_inst (
    .core_clk_i(core_clk_i), .rstn_i(rstn_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .vpp_present_i(vpp_present_i), .fetch_addr_i(fetch_addr_i),
    .fetch_from_flash_i(fetch_from_flash_i), .fetch_allow_o(fetch_allow_o), .cell_req_o(cell_req_o),
    .cell_ack_i(cell_ack_i), .cell_ok_i(cell_ok_i), .busy_o(busy_o));

// >>> fpe_flash_cmd_tb.sv
/*
 self-checking bench for the flash program/erase command block.
 assumes fpe_pkg compiled first; the bench acts as cpu master and cell port.
*/
`timescale 1ns/10ps
module fpe_flash_cmd_tb_top
    import fpe_pkg::*;
;
    logic          core_clk_i, rstn_i, avs_read_i, avs_write_i, vpp_present_i;
    logic          fetch_from_flash_i, cell_ack_i, cell_ok_i;
    logic          avs_waitrequest_o, fetch_allow_o, busy_o;
    logic [7:0]    avs_address_i;
    logic [31:0]   avs_writedata_i, avs_readdata_o, rd;
    logic [23:0]   fetch_addr_i;
    fpe_cell_req_t cell_req_o;
    int            err_count, checks, cnt;

    fpe_flash_cmd fpe_flash_cmd_inst (
        .core_clk_i(core_clk_i), .rstn_i(rstn_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
        .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
        .avs_waitrequest_o(avs_waitrequest_o), .vpp_present_i(vpp_present_i), .fetch_addr_i(fetch_addr_i),
        .fetch_from_flash_i(fetch_from_flash_i), .fetch_allow_o(fetch_allow_o), .cell_req_o(cell_req_o),
        .cell_ack_i(cell_ack_i), .cell_ok_i(cell_ok_i), .busy_o(busy_o));

    initial
    begin
        core_clk_i = 1'b0;
        forever #2.5 core_clk_i = ~core_clk_i;
    end

    // cell port: acknowledges each request after 11 cycles
    always @(posedge core_clk_i)
    begin
        if (cell_ack_i || cell_req_o.req !== 1'b1)
        begin
            cell_ack_i <= 1'b0;
            cnt        <= 0;
        end
        else
        begin
            cnt <= cnt + 1;
            if (cnt == 10)
                cell_ack_i <= 1'b1;
        end
    end

    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk_i);
        avs_address_i   <= a;
        avs_writedata_i <= d;
        avs_write_i     <= w;
        avs_read_i      <= !w;
        // waitrequest and read data are taken at the same rising edge
        @(posedge core_clk_i);
        while (avs_waitrequest_o !== 1'b0)
            @(posedge core_clk_i);
        rd = avs_readdata_o;
        avs_write_i <= 1'b0;
        avs_read_i  <= 1'b0;
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(rd, e);
    endtask

    // load, unlock, wait, then compare the result code
    task automatic run(input logic [7:0] rc, input logic m, input logic [15:0] c0, c1, c2, c3,
                       input logic [15:0] c4 = 16'h32, stk = 16'h32, input logic vp = 1'b1, ok = 1'b1);
        int n;
        @(posedge core_clk_i);
        vpp_present_i <= vp;
        cell_ok_i     <= ok;
        bus(1'b1, 8'h14, {31'h0, m});
        bus(1'b1, 8'h00, {16'h0, c0});
        bus(1'b1, 8'h04, {16'h0, c1});
        bus(1'b1, 8'h08, {16'h0, c2});
        bus(1'b1, 8'h0C, {16'h0, c3});
        bus(1'b1, 8'h10, {16'h0, c4});
        bus(1'b1, 8'h1C, {16'h0, stk});
        bus(1'b1, 8'h2C, 32'h8000);
        bus(1'b1, 8'h2C, 32'h8000);
        n = 0;
        repeat (2) @(posedge core_clk_i);
        while (busy_o !== 1'b0 && n < 5000)
        begin
            @(posedge core_clk_i);
            n++;
        end
        chk({31'h0, busy_o}, 32'h0);
        bus(1'b0, 8'h00, 32'h0);
        chk({24'h0, rd[7:0]}, {24'h0, rc});
    endtask

    initial
    begin
        #300000;
        err_count++;
        $display("MISMATCH t=%0t watchdog expired", $time);
        end_sim();
    end

    initial
    begin
        rstn_i = 1'b0;
        {avs_read_i, avs_write_i, vpp_present_i, fetch_from_flash_i, cell_ok_i} = 5'h0;
        avs_address_i = 8'h0;
        avs_writedata_i = 32'h0;
        fetch_addr_i = 24'h0;
        err_count = 0;
        checks = 0;
        repeat (5) @(posedge core_clk_i);
        rstn_i <= 1'b1;
        #1 chk({31'h0, fetch_allow_o}, 32'h1);
        rdc(8'h00, 32'h0);
        rdc(8'h30, 32'h0);
        bus(1'b1, 8'h20, 32'h1234);
        run(8'h00, 1'b0, 16'h55A1, 16'h8100, 16'h1234, 16'h0);
        rdc(8'h20, 32'h0);
        run(8'h04, 1'b0, 16'h55A1, 16'h0100, 16'h1234, 16'h0, 16'h1E);
        run(8'h00, 1'b1, 16'h55A1, 16'h0100, 16'h1234, 16'h0, 16'h1F4);
        run(8'h00, 1'b0, 16'hDD41, 16'h8104, 16'h3456, 16'h4567);
        run(8'h04, 1'b0, 16'h55A1, 16'h8101, 16'h1234, 16'h0);
        run(8'hFF, 1'b0, 16'h1231, 16'h8100, 16'h1234, 16'h0);
        run(8'h05, 1'b0, 16'h55A1, 16'h8100, 16'h1234, 16'h0, 16'h1D);
        run(8'h05, 1'b0, 16'h55A1, 16'h8100, 16'h1234, 16'h0, 16'h1F5);
        run(8'h06, 1'b0, 16'h55A1, 16'h8100, 16'h1234, 16'h0, 16'h32, 16'h31);
        run(8'h02, 1'b0, 16'h55A1, 16'h8100, 16'h1234, 16'h0, 16'h32, 16'h32, 1'b0);
        run(8'h03, 1'b0, 16'h55A1, 16'h8100, 16'h1234, 16'h0, 16'h32, 16'h32, 1'b1, 1'b0);
        run(8'h07, 1'b0, 16'hEEEE, 16'h5555, 16'h1, 16'h2);
        run(8'h07, 1'b0, 16'hEEEE, 16'h5555, 16'h4, 16'h4);
        run(8'h00, 1'b0, 16'hEEEE, 16'h5555, 16'h3, 16'h3);
        run(8'h0A, 1'b0, 16'hAA51, 16'h8000, 16'h7FFE, 16'h8000);
        run(8'h0A, 1'b0, 16'hAA51, 16'h8000, 16'hC000, 16'h8000);
        run(8'h09, 1'b1, 16'hAA51, 16'h8000, 16'h8000, 16'h0);
        run(8'h00, 1'b0, 16'hAA51, 16'h8000, 16'h8004, 16'h0100);
        rdc(8'h04, 32'h8004);
        run(8'h00, 1'b0, 16'h7777, 16'h0, 16'h0, 16'h0);
        bus(1'b1, 8'h00, 32'h55A1);
        bus(1'b1, 8'h2C, 32'h8000);
        bus(1'b1, 8'h0C, 32'h0);
        bus(1'b1, 8'h2C, 32'h8000);
        repeat (4) @(posedge core_clk_i);
        chk({31'h0, busy_o}, 32'h0);
        rdc(8'h00, 32'h55A1);
        run(8'h00, 1'b0, 16'hCCCC, 16'h5555, 16'h3333, 16'hAAAA);
        rdc(8'h14, 32'h2);
        @(posedge core_clk_i);
        fetch_addr_i <= 24'h001000;
        @(posedge core_clk_i);
        #1 chk({31'h0, fetch_allow_o}, 32'h0);
        @(posedge core_clk_i);
        fetch_from_flash_i <= 1'b1;
        @(posedge core_clk_i);
        #1 chk({31'h0, fetch_allow_o}, 32'h1);
        run(8'h01, 1'b0, 16'h55A1, 16'h8100, 16'h1234, 16'h0);
        end_sim();
    end
endmodule // fpe_flash_cmd_tb_top
